// ===== hdl/dpr_pkg.sv
// shared constants, types and helper functions of the dual-port block ram
package dpr_pkg;
  // array and port geometry
  localparam int MEM_BITS = 18432;
  localparam int AW = 14;
  localparam int DW = 36;
  localparam int BEW = 4;
  localparam int LANE = 9;
  localparam int IDXW = 11;
  localparam int CFG_W = 7;
  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_A_OFS = 8'h04;
  localparam logic [7:0] CFG_B_OFS = 8'h08;
  localparam logic [7:0] INIT_ADDR_OFS = 8'h0C;
  localparam logic [7:0] INIT_DATA_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  // port width codes
  localparam logic [2:0] W_X1 = 3'h0;
  localparam logic [2:0] W_X2 = 3'h1;
  localparam logic [2:0] W_X4 = 3'h2;
  localparam logic [2:0] W_X9 = 3'h3;
  localparam logic [2:0] W_X18 = 3'h4;
  localparam logic [2:0] W_X36 = 3'h5;
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {MODE_SP = 2'h0, MODE_TDP = 2'h1, MODE_PDP = 2'h2} dpr_ram_mode_type;
  typedef enum logic [1:0] {WM_NORMAL = 2'h0, WM_THROUGH = 2'h1, WM_RBW = 2'h2} dpr_wmode_type;
  typedef enum logic {PH_CONFIG = 1'h0, PH_RUN = 1'h1} dpr_phase_type;
  // per-port configuration word, bit 6 down to bit 0
  typedef struct packed {
    logic async_clr;
    logic out_reg;
    dpr_wmode_type wmode;
    logic [2:0] width;
  } dpr_cfg_type;
  // one registered port request
  typedef struct packed {
    logic ce;
    logic we;
    logic [BEW-1:0] be;
    logic [AW-1:0] addr;
    logic [DW-1:0] din;
  } dpr_in_type;
  // reset values
  localparam dpr_cfg_type CFG_RST = dpr_cfg_type'(7'h00);
  localparam dpr_ram_mode_type MODE_RST = MODE_SP;
  localparam logic [IDXW-1:0] IDX_RST = 11'h000;
  //////////////////////////////////////////////////////////////////////////////
  // data bits of a port for a width code
  function automatic logic [5:0] width_of(input logic [2:0] w);
    case (w)
      W_X1: return 6'h01;
      W_X2: return 6'h02;
      W_X4: return 6'h04;
      W_X9: return 6'h09;
      W_X18: return 6'h12;
      default: return 6'h24;
    endcase
  endfunction
  // ones in the low bits that a port of this width uses
  function automatic logic [DW-1:0] wmask(input logic [2:0] w);
    return {DW{1'b1}} >> (DW - int'(width_of(w)));
  endfunction
  // first array bit of a word: words packed lsb first, one after another
  function automatic logic [14:0] base_of(input logic [2:0] w, input logic [AW-1:0] a);
    case (w)
      W_X1: return {1'b0, a};
      W_X2: return {1'b0, a[12:0], 1'b0};
      W_X4: return {1'b0, a[11:0], 2'h0};
      W_X9: return 15'(a[10:0]) * 15'h0009;
      W_X18: return 15'(a[9:0]) * 15'h0012;
      default: return 15'(a[8:0]) * 15'h0024;
    endcase
  endfunction
  // byte enables only steer the 18 and 36 bit widths
  function automatic logic lane_ok(input logic [2:0] w, input logic [BEW-1:0] be, input int i);
    if (w == W_X18 || w == W_X36)
      return be[i / LANE];
    return 1'b1;
  endfunction
endpackage

// ===== hdl/dpr_port_out.sv
// output latch and optional output register of one ram port
`timescale 1ns/100ps
module dpr_port_out (
  input wire logic pclk,
  input wire logic clr_async_n,
  input wire logic clr_sync,
  input wire logic load,
  input wire logic [dpr_pkg::DW-1:0] load_data,
  input wire logic out_ce,
  input wire logic out_reg,
  output logic [dpr_pkg::DW-1:0] dout
);

  typedef struct packed {
    logic [dpr_pkg::DW-1:0] latch;
    logic [dpr_pkg::DW-1:0] pipe;
  } dpr_out_type;

  dpr_out_type out_ff;
  dpr_out_type nxt_out;

  //////////////////////////////////////////////////////////////////////////////
  // synchronous clear beats a load in the same cycle
  always_comb
  begin
    nxt_out = out_ff;
    if (clr_sync)
      nxt_out = '0; // [RULE11] [RULE12]
    else
    begin
      if (load)
        nxt_out.latch = load_data;
      if (out_ce)
        nxt_out.pipe = out_ff.latch; // [RULE7] [RULE15]
    end
  end

  // asynchronous clear arrives already combined from its sources
  always_ff @(posedge pclk or negedge clr_async_n)
  begin
    if (!clr_async_n)
      out_ff <= '0; // [RULE11]
    else
      out_ff <= nxt_out;
  end

  // pipe stage adds one cycle when selected
  assign dout = out_reg ? out_ff.pipe : out_ff.latch; // [RULE7]

endmodule

// ===== hdl/dpr_top.sv
// dual-port block ram: shared array, port input stages, apb configuration
// Function
// [RULE1] six shapes; no 36-bit width in true dual
// [RULE2] each port picks own width on shared array
// [RULE3] bits laid out word by word, lsb first
// [RULE4] array preloadable before operation starts
// [RULE5] preloaded array with writes off acts as rom
// [RULE6] address and write data registered on clock
// [RULE7] optional output register adds one cycle
// [RULE8] normal mode: output holds during writes
// [RULE9] write-through mode: written data shown on output
// [RULE10] read-before-write shows old word, wide widths only
// [RULE11] output clear asynchronous or synchronous, configurable
// [RULE12] local reset clears only its own port output
// [RULE13] global active-low reset clears both outputs
// [RULE14] port configuration frozen once operation starts
// [RULE15] separate input/output clock enables, parity, byte enables
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module dpr_top #(
  parameter logic RBW_EN = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_reset_n,
  input wire logic port_a_ce_in,
  input wire logic port_a_ce_out,
  input wire logic port_a_we,
  input wire logic [dpr_pkg::BEW-1:0] port_a_be,
  input wire logic [dpr_pkg::AW-1:0] port_a_addr,
  input wire logic [dpr_pkg::DW-1:0] port_a_din,
  input wire logic port_a_local_reset,
  output logic [dpr_pkg::DW-1:0] port_a_dout,
  input wire logic port_b_ce_in,
  input wire logic port_b_ce_out,
  input wire logic port_b_we,
  input wire logic [dpr_pkg::BEW-1:0] port_b_be,
  input wire logic [dpr_pkg::AW-1:0] port_b_addr,
  input wire logic [dpr_pkg::DW-1:0] port_b_din,
  input wire logic port_b_local_reset,
  output logic [dpr_pkg::DW-1:0] port_b_dout
);

  typedef struct packed {
    logic [dpr_pkg::MEM_BITS-1:0] mem;
    dpr_pkg::dpr_phase_type phase;
    dpr_pkg::dpr_ram_mode_type mode;
    dpr_pkg::dpr_cfg_type cfg_a;
    dpr_pkg::dpr_cfg_type cfg_b;
    logic [dpr_pkg::IDXW-1:0] init_idx;
    logic refused;
    logic [31:0] prdata;
    logic pslverr;
    dpr_pkg::dpr_in_type in_a;
    dpr_pkg::dpr_in_type in_b;
  } dpr_state_type;

  dpr_state_type st_ff;
  dpr_state_type nxt_st;
  logic run;
  logic start_ok;
  logic [1:0] new_mode;
  logic [dpr_pkg::DW-1:0] old_a;
  logic [dpr_pkg::DW-1:0] old_b;
  logic [dpr_pkg::DW-1:0] init_word;
  logic act_a;
  logic act_b;
  logic wr_a;
  logic wr_b;
  logic ld_a;
  logic ld_b;
  logic [dpr_pkg::DW-1:0] val_a;
  logic [dpr_pkg::DW-1:0] val_b;
  logic clr_a;
  logic clr_b;
  logic async_n_a;
  logic async_n_b;
  logic sync_a;
  logic sync_b;

  //////////////////////////////////////////////////////////////////////////////
  // read one word at its linear bit position, upper bits zero
  function automatic logic [dpr_pkg::DW-1:0] rd_word(
    input logic [dpr_pkg::MEM_BITS-1:0] m,
    input logic [2:0] w,
    input logic [dpr_pkg::AW-1:0] a
  );
    int base;
    logic [dpr_pkg::DW-1:0] r;
    base = int'(dpr_pkg::base_of(w, a)); // [RULE3]
    r = '0;
    for (int i = 0; i < dpr_pkg::DW; i++)
      if (i < int'(dpr_pkg::width_of(w)))
        r[i] = m[base + i];
    return r;
  endfunction

  // write one word, lane by lane where byte enables apply
  function automatic logic [dpr_pkg::MEM_BITS-1:0] wr_word(
    input logic [dpr_pkg::MEM_BITS-1:0] m,
    input logic [2:0] w,
    input dpr_pkg::dpr_in_type p
  );
    int base;
    base = int'(dpr_pkg::base_of(w, p.addr)); // [RULE3]
    for (int i = 0; i < dpr_pkg::DW; i++)
      if (i < int'(dpr_pkg::width_of(w)) && dpr_pkg::lane_ok(w, p.be, i))
        m[base + i] = p.din[i]; // [RULE15]
    return m;
  endfunction

  // shape check done on every configuration write
  function automatic logic shape_ok(input dpr_pkg::dpr_cfg_type c);
    return c.width <= dpr_pkg::W_X36 && c.wmode != dpr_pkg::dpr_wmode_type'(2'h3);
  endfunction

  // full check of a port setup against the ram mode at start
  function automatic logic cfg_ok(input logic [1:0] md, input dpr_pkg::dpr_cfg_type c);
    logic ok;
    ok = shape_ok(c);
    if (md == dpr_pkg::MODE_TDP && c.width == dpr_pkg::W_X36)
      ok = 1'b0; // [RULE1]
    if (c.wmode == dpr_pkg::WM_RBW && (!RBW_EN || c.width < dpr_pkg::W_X9))
      ok = 1'b0; // [RULE10]
    return ok;
  endfunction

  // latch update for one port: {load, value}
  function automatic logic [dpr_pkg::DW:0] pick(
    input dpr_pkg::dpr_cfg_type c,
    input logic wr,
    input logic rd,
    input logic [dpr_pkg::DW-1:0] din,
    input logic [dpr_pkg::DW-1:0] old
  );
    if (wr)
      case (c.wmode)
        dpr_pkg::WM_THROUGH: return {1'b1, din & dpr_pkg::wmask(c.width)}; // [RULE9]
        dpr_pkg::WM_RBW: return {1'b1, old}; // [RULE10]
        default: return {1'b0, old}; // [RULE8]
      endcase
    if (rd)
      return {1'b1, old};
    return {1'b0, old};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decode shared by the bus and the ports
  assign run = st_ff.phase == dpr_pkg::PH_RUN;
  assign new_mode = pwdata[dpr_pkg::CTRL_MODE_LSB +: 2];
  assign start_ok = new_mode != 2'h3 && cfg_ok(new_mode, st_ff.cfg_a)
    && (new_mode == dpr_pkg::MODE_SP || cfg_ok(new_mode, st_ff.cfg_b));
  // operations launched from the input registers one cycle after capture
  assign act_a = st_ff.in_a.ce;
  assign act_b = st_ff.in_b.ce && st_ff.mode != dpr_pkg::MODE_SP;
  // no write enable, no change: a preloaded array serves as a rom
  assign wr_a = act_a && st_ff.in_a.we; // [RULE5]
  assign wr_b = act_b && st_ff.in_b.we && st_ff.mode == dpr_pkg::MODE_TDP; // [RULE5]

  // all state moves here; the array is read before this cycle's writes
  always_comb
  begin
    nxt_st = st_ff;
    old_a = rd_word(st_ff.mem, st_ff.cfg_a.width, st_ff.in_a.addr); // [RULE2]
    old_b = rd_word(st_ff.mem, st_ff.cfg_b.width, st_ff.in_b.addr); // [RULE2]
    init_word = rd_word(st_ff.mem, dpr_pkg::W_X9, {3'h0, st_ff.init_idx});
    // answer and error are settled in setup, so pready can stay high
    if (psel && !penable)
    begin
      nxt_st.prdata = 32'h0000_0000;
      nxt_st.pslverr = 1'b0;
      case (paddr)
        dpr_pkg::CTRL_OFS:
        begin
          nxt_st.prdata[dpr_pkg::CTRL_RUN_BIT] = run;
          nxt_st.prdata[dpr_pkg::CTRL_MODE_LSB +: 2] = st_ff.mode;
          nxt_st.pslverr = pwrite && (run || (pwdata[dpr_pkg::CTRL_RUN_BIT] && !start_ok));
        end
        dpr_pkg::CFG_A_OFS:
        begin
          nxt_st.prdata[dpr_pkg::CFG_W-1:0] = st_ff.cfg_a;
          nxt_st.pslverr = pwrite && (run
            || !shape_ok(dpr_pkg::dpr_cfg_type'(pwdata[dpr_pkg::CFG_W-1:0]))); // [RULE14]
        end
        dpr_pkg::CFG_B_OFS:
        begin
          nxt_st.prdata[dpr_pkg::CFG_W-1:0] = st_ff.cfg_b;
          nxt_st.pslverr = pwrite && (run
            || !shape_ok(dpr_pkg::dpr_cfg_type'(pwdata[dpr_pkg::CFG_W-1:0]))); // [RULE14]
        end
        dpr_pkg::INIT_ADDR_OFS:
        begin
          nxt_st.prdata[dpr_pkg::IDXW-1:0] = st_ff.init_idx;
          nxt_st.pslverr = pwrite && run;
        end
        dpr_pkg::INIT_DATA_OFS:
        begin
          nxt_st.prdata[dpr_pkg::LANE-1:0] = init_word[dpr_pkg::LANE-1:0];
          nxt_st.pslverr = pwrite && run; // [RULE4]
        end
        dpr_pkg::STATUS_OFS:
        begin
          nxt_st.prdata[dpr_pkg::STAT_RUN_BIT] = run;
          nxt_st.prdata[dpr_pkg::STAT_REFUSED_BIT] = st_ff.refused;
          nxt_st.pslverr = pwrite;
        end
        default:
          nxt_st.pslverr = 1'b1;
      endcase
    end
    // access: a write takes effect at the edge that completes it
    if (psel && penable)
    begin
      nxt_st.refused = st_ff.pslverr;
      if (pwrite && !st_ff.pslverr)
        case (paddr)
          dpr_pkg::CTRL_OFS:
          begin
            nxt_st.mode = dpr_pkg::dpr_ram_mode_type'(new_mode);
            if (pwdata[dpr_pkg::CTRL_RUN_BIT])
              nxt_st.phase = dpr_pkg::PH_RUN; // [RULE14]
          end
          dpr_pkg::CFG_A_OFS:
            nxt_st.cfg_a = dpr_pkg::dpr_cfg_type'(pwdata[dpr_pkg::CFG_W-1:0]); // [RULE2]
          dpr_pkg::CFG_B_OFS:
            nxt_st.cfg_b = dpr_pkg::dpr_cfg_type'(pwdata[dpr_pkg::CFG_W-1:0]); // [RULE2]
          dpr_pkg::INIT_ADDR_OFS:
            nxt_st.init_idx = pwdata[dpr_pkg::IDXW-1:0];
          dpr_pkg::INIT_DATA_OFS:
          begin
            // preload in 9-bit words, pointer steps after each
            nxt_st.mem = wr_word(st_ff.mem, dpr_pkg::W_X9,
              '{1'b1, 1'b1, 4'hF, {3'h0, st_ff.init_idx}, {27'h0, pwdata[8:0]}}); // [RULE4]
            nxt_st.init_idx = st_ff.init_idx + 11'h001;
          end
          default:
            ;
        endcase
    end
    // input registers: port requests held only while running
    if (port_a_ce_in)
      nxt_st.in_a = '{run, port_a_we, port_a_be, port_a_addr, port_a_din}; // [RULE6] [RULE15]
    else
      nxt_st.in_a.ce = 1'b0;
    if (port_b_ce_in)
      nxt_st.in_b = '{run, port_b_we, port_b_be, port_b_addr, port_b_din}; // [RULE6] [RULE15]
    else
      nxt_st.in_b.ce = 1'b0;
    // array stage; on a shared bit port a's write lands last and wins
    if (wr_b)
      nxt_st.mem = wr_word(st_ff.mem, st_ff.cfg_b.width, st_ff.in_b); // [RULE2]
    if (wr_a)
      nxt_st.mem = wr_word(nxt_st.mem, st_ff.cfg_a.width, st_ff.in_a); // [RULE2]
    // pseudo dual: port a only writes, port b only reads
    {ld_a, val_a} = pick(st_ff.cfg_a, wr_a, act_a && st_ff.mode != dpr_pkg::MODE_PDP,
      st_ff.in_a.din, old_a);
    {ld_b, val_b} = pick(st_ff.cfg_b, wr_b, act_b && !wr_b, st_ff.in_b.din, old_b);
  end

  // configuration and array are cleared by the bus reset only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.mode <= dpr_pkg::MODE_RST;
      st_ff.cfg_a <= dpr_pkg::CFG_RST;
      st_ff.cfg_b <= dpr_pkg::CFG_RST;
      st_ff.init_idx <= dpr_pkg::IDX_RST;
    end
    else
      st_ff <= nxt_st;
  end
  assign pready = 1'b1;
  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.pslverr;

  //////////////////////////////////////////////////////////////////////////////
  // output clears: a derived asynchronous clear is glitch-prone, keep inputs clean
  assign clr_a = port_a_local_reset || !global_reset_n; // [RULE12] [RULE13]
  assign clr_b = port_b_local_reset || !global_reset_n; // [RULE12] [RULE13]
  assign async_n_a = presetn && !(st_ff.cfg_a.async_clr && clr_a); // [RULE11]
  assign async_n_b = presetn && !(st_ff.cfg_b.async_clr && clr_b); // [RULE11]
  assign sync_a = !st_ff.cfg_a.async_clr && clr_a; // [RULE11]
  assign sync_b = !st_ff.cfg_b.async_clr && clr_b; // [RULE11]

  dpr_port_out u_out_a (
    .pclk(pclk),
    .clr_async_n(async_n_a),
    .clr_sync(sync_a),
    .load(ld_a),
    .load_data(val_a),
    .out_ce(port_a_ce_out),
    .out_reg(st_ff.cfg_a.out_reg),
    .dout(port_a_dout)
  );
  dpr_port_out u_out_b (
    .pclk(pclk),
    .clr_async_n(async_n_b),
    .clr_sync(sync_b),
    .load(ld_b),
    .load_data(val_b),
    .out_ce(port_b_ce_out),
    .out_reg(st_ff.cfg_b.out_reg),
    .dout(port_b_dout)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks on the design's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cfg_frozen: assert property ( // [RULE14]
    run |=> $stable(st_ff.cfg_a) && $stable(st_ff.cfg_b) && $stable(st_ff.mode))
    else $error("configuration changed while running");
  a_tdp_shape: assert property ( // [RULE1]
    run && st_ff.mode == dpr_pkg::MODE_TDP |->
      st_ff.cfg_a.width != dpr_pkg::W_X36 && st_ff.cfg_b.width != dpr_pkg::W_X36)
    else $error("36-bit port in true dual mode");
  a_in_capture: assert property ( // [RULE6]
    run && port_a_ce_in |=> st_ff.in_a.ce && st_ff.in_a.addr == $past(port_a_addr)
      && st_ff.in_a.din == $past(port_a_din))
    else $error("port a input register missed a request");
  a_read_data: assert property ( // [RULE2]
    ld_a && !wr_a && !st_ff.cfg_a.out_reg && !clr_a |=>
      clr_a || port_a_dout == $past(old_a))
    else $error("port a read data wrong");
  a_normal_hold: assert property ( // [RULE8]
    wr_a && st_ff.cfg_a.wmode == dpr_pkg::WM_NORMAL && !st_ff.cfg_a.out_reg && !clr_a
      |=> clr_a || $stable(port_a_dout))
    else $error("normal write changed port a output");
  a_write_thru: assert property ( // [RULE9]
    wr_a && st_ff.cfg_a.wmode == dpr_pkg::WM_THROUGH && !st_ff.cfg_a.out_reg && !clr_a
      |=> clr_a || port_a_dout == $past(val_a))
    else $error("write-through data missing on port a");
  a_rbw_old: assert property ( // [RULE10]
    wr_b && st_ff.cfg_b.wmode == dpr_pkg::WM_RBW && !st_ff.cfg_b.out_reg && !clr_b
      |=> clr_b || port_b_dout == $past(old_b))
    else $error("read-before-write lost old word on port b");
  a_oreg_lag: assert property ( // [RULE7]
    ld_a && st_ff.cfg_a.out_reg && !clr_a ##1 port_a_ce_out && !clr_a
      |=> clr_a || port_a_dout == $past(val_a, 2))
    else $error("output register latency wrong on port a");
  a_local_clear: assert property ( // [RULE12]
    port_a_local_reset && !st_ff.cfg_a.async_clr && global_reset_n && !port_b_local_reset
      && !ld_b && !port_b_ce_out |=> port_a_dout == '0 && $stable(port_b_dout))
    else $error("local clear of port a wrong");
  a_async_clear: assert property ( // [RULE11]
    port_b_local_reset && st_ff.cfg_b.async_clr |-> port_b_dout == '0)
    else $error("asynchronous clear of port b not immediate");
  a_global_clear: assert property ( // [RULE13]
    !global_reset_n && !st_ff.cfg_a.async_clr && !st_ff.cfg_b.async_clr
      |=> port_a_dout == '0 && port_b_dout == '0)
    else $error("global reset left an output set");
  c_start: cover property ($rose(run));
  c_thru: cover property (wr_a && st_ff.cfg_a.wmode == dpr_pkg::WM_THROUGH);
  c_rbw: cover property (wr_b && st_ff.cfg_b.wmode == dpr_pkg::WM_RBW);
  c_mixed: cover property (act_a && act_b && st_ff.cfg_a.width != st_ff.cfg_b.width);

endmodule

// ===== verification/dpr_fabric.sv
// user fabric model that drives both ram ports
`timescale 1ns/100ps
module dpr_fabric (
  input wire logic pclk,
  output dpr_pkg::dpr_in_type req_a,
  output dpr_pkg::dpr_in_type req_b
);
  // both ports idle from time zero
  initial
  begin
    req_a = '0;
    req_b = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one request, held for exactly one edge, then dropped
  task automatic op(input logic pb, input logic we, input logic [dpr_pkg::AW-1:0] a,
    input logic [dpr_pkg::DW-1:0] d);
    dpr_pkg::dpr_in_type r;
    r = '{ce: 1'b1, we: we, be: 4'hF, addr: a, din: d};
    @(posedge pclk);
    if (pb)
      req_b <= r;
    else
      req_a <= r;
    @(posedge pclk);
    // released lines show the inverse so stale values are never reused
    r.ce = 1'b0;
    r.we = 1'b0;
    r.addr = ~a;
    r.din = ~d;
    if (pb)
      req_b <= r;
    else
      req_a <= r;
  endtask
endmodule

// ===== verification/tb_dpr_top.sv
// self-checking bench of the dual-port block ram
`timescale 1ns/100ps
module tb_dpr_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic grn = 1'b1;
  logic lra = 1'b0;
  logic lrb = 1'b0;
  logic ceo = 1'b1;
  logic [35:0] douta;
  logic [35:0] doutb;
  dpr_pkg::dpr_in_type req_a;
  dpr_pkg::dpr_in_type req_b;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [8:0] w [4] = '{9'h1A5, 9'h0C3, 9'h155, 9'h0AA};
  //////////////////////////////////////////////////////////////////////////////
  always #50 pclk = ~pclk;
  dpr_fabric fab (.pclk(pclk), .req_a(req_a), .req_b(req_b));
  dpr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_reset_n(grn), .port_a_ce_in(req_a.ce),
    .port_a_ce_out(ceo), .port_a_we(req_a.we), .port_a_be(req_a.be),
    .port_a_addr(req_a.addr), .port_a_din(req_a.din), .port_a_local_reset(lra),
    .port_a_dout(douta), .port_b_ce_in(req_b.ce), .port_b_ce_out(ceo),
    .port_b_we(req_b.we), .port_b_be(req_b.be), .port_b_addr(req_b.addr),
    .port_b_din(req_b.din), .port_b_local_reset(lrb), .port_b_dout(doutb));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far above the 140 or so cycles the tests need
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; waits on pready, never assumes its timing
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout ends this wait
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("pslverr", 36'(e), 36'(ee));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("pready", 36'(pready), 36'h1);
    chk("pslverr", 36'(e), 36'(ee));
    if (ee == 1'b0)
      chk("prdata", 36'(r), 36'(v));
  endtask
  function automatic logic [31:0] cw(input dpr_pkg::dpr_wmode_type m, input logic [2:0] wd,
    input logic o);
    dpr_pkg::dpr_cfg_type c;
    c = '{async_clr: 1'b0, out_reg: o, wmode: m, width: wd};
    return 32'(c);
  endfunction
  // wait n edges and look at one port's output once it has settled
  task automatic pc(input int n, input logic pb, input logic [35:0] e);
    repeat (n) @(posedge pclk);
    #1;
    chk(pb ? "port_b_dout" : "port_a_dout", pb ? doutb : douta, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(dpr_pkg::CFG_A_OFS, 32'h0, 1'b0);
    rd(dpr_pkg::STATUS_OFS, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(dpr_pkg::STATUS_OFS, 32'h1, 1'b1);
    wr(dpr_pkg::CFG_A_OFS, 32'h6, 1'b1);
    // preload four 9-bit words, then read one back
    wr(dpr_pkg::INIT_ADDR_OFS, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++)
      wr(dpr_pkg::INIT_DATA_OFS, 32'(w[i]), 1'b0);
    wr(dpr_pkg::INIT_ADDR_OFS, 32'h1, 1'b0);
    rd(dpr_pkg::INIT_DATA_OFS, 32'(w[1]), 1'b0);
    // illegal shapes refused at start, then a legal true dual start
    wr(dpr_pkg::CFG_A_OFS, cw(dpr_pkg::WM_RBW, dpr_pkg::W_X1, 1'b0), 1'b0);
    wr(dpr_pkg::CFG_B_OFS, cw(dpr_pkg::WM_NORMAL, dpr_pkg::W_X36, 1'b1), 1'b0);
    wr(dpr_pkg::CTRL_OFS, 32'h3, 1'b1);
    wr(dpr_pkg::CFG_A_OFS, cw(dpr_pkg::WM_THROUGH, dpr_pkg::W_X9, 1'b0), 1'b0);
    wr(dpr_pkg::CTRL_OFS, 32'h3, 1'b1);
    wr(dpr_pkg::CFG_B_OFS, cw(dpr_pkg::WM_NORMAL, dpr_pkg::W_X18, 1'b1), 1'b0);
    wr(dpr_pkg::CTRL_OFS, 32'h3, 1'b0);
    rd(dpr_pkg::STATUS_OFS, 32'h1, 1'b0);
    wr(dpr_pkg::CFG_A_OFS, 32'h0, 1'b1);
    rd(dpr_pkg::STATUS_OFS, 32'h3, 1'b0);
    rd(dpr_pkg::CFG_A_OFS, cw(dpr_pkg::WM_THROUGH, dpr_pkg::W_X9, 1'b0), 1'b0);
    // rom reads: x9 on a, x18 with output register on b
    fab.op(1'b0, 1'b0, 14'h3, 36'h0);
    pc(1, 1'b0, 36'(w[3]));
    fab.op(1'b1, 1'b0, 14'h0, 36'h0);
    pc(1, 1'b1, 36'h0);
    pc(1, 1'b1, 36'({w[1], w[0]}));
    // write-through on a, seen by b on the shared array
    fab.op(1'b0, 1'b1, 14'h2, 36'hFFFFFF1E7);
    pc(1, 1'b0, 36'h1E7);
    fab.op(1'b1, 1'b0, 14'h1, 36'h0);
    pc(2, 1'b1, 36'({w[3], 9'h1E7}));
    // normal write on b holds the output, the read after returns it
    fab.op(1'b1, 1'b1, 14'h5, 36'h5A5A5A5A5);
    pc(2, 1'b1, 36'({w[3], 9'h1E7}));
    fab.op(1'b1, 1'b0, 14'h5, 36'h0);
    pc(2, 1'b1, 36'h1A5A5);
    // local clear of a only; b's pipe is frozen so its hold is visible
    @(posedge pclk);
    lra <= 1'b1;
    ceo <= 1'b0;
    @(posedge pclk);
    lra <= 1'b0;
    ceo <= 1'b1;
    #1;
    chk("port_a_dout", douta, 36'h0);
    chk("port_b_dout", doutb, 36'h1A5A5);
    fab.op(1'b0, 1'b0, 14'h3, 36'h0);
    pc(1, 1'b0, 36'(w[3]));
    // device-wide clear hits both
    @(posedge pclk);
    grn <= 1'b0;
    @(posedge pclk);
    grn <= 1'b1;
    #1;
    chk("port_a_dout", douta, 36'h0);
    chk("port_b_dout", doutb, 36'h0);
    // reset in mid-run: back to configuration, array and outputs cleared
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(dpr_pkg::STATUS_OFS, 32'h0, 1'b0);
    // true dual: x18 normal on a, x9 read-before-write with async clear on b
    wr(dpr_pkg::CFG_A_OFS, cw(dpr_pkg::WM_NORMAL, dpr_pkg::W_X18, 1'b0), 1'b0);
    wr(dpr_pkg::CFG_B_OFS, cw(dpr_pkg::WM_RBW, dpr_pkg::W_X9, 1'b0) | 32'h40, 1'b0);
    wr(dpr_pkg::CTRL_OFS, 32'h3, 1'b0);
    fab.op(1'b0, 1'b1, 14'h0, 36'h00002B3C6);
    pc(1, 1'b0, 36'h0);
    fab.op(1'b0, 1'b0, 14'h0, 36'h0);
    pc(1, 1'b0, 36'h2B3C6);
    fab.op(1'b0, 1'b1, 14'h0, 36'h000011111);
    pc(1, 1'b0, 36'h2B3C6);
    fab.op(1'b1, 1'b1, 14'h0, 36'h0000000AB);
    pc(1, 1'b1, 36'h111);
    fab.op(1'b0, 1'b0, 14'h0, 36'h0);
    pc(1, 1'b0, 36'h110AB);
    // asynchronous clear of b shows before the next edge
    @(posedge pclk);
    lrb <= 1'b1;
    #1;
    chk("port_b_dout", doutb, 36'h0);
    chk("port_a_dout", douta, 36'h110AB);
    @(posedge pclk);
    lrb <= 1'b0;
    end_of_test();
  end
endmodule
